// ---- verilog/pbm_pkg.sv ----
package pbm_pkg;

    // clock rate and the timed behaviours derived from it
    localparam int CLK_MHZ      = 125;
    localparam int DEAD_TIME_US = 550;
    localparam int DEAD_CYCLES  = DEAD_TIME_US * CLK_MHZ;

    // length of the reset process, shared by hardware and software reset
    localparam int         RST_CNT_W = 4;
    localparam logic [3:0] RST_LOAD  = 4'h8;
    localparam logic [3:0] RST_LAST  = 4'h1;

    // register map: one 16-bit register at address 0
    localparam int         REG_W     = 16;
    localparam int         ADDR_W    = 5;
    localparam logic [4:0] REG_BMC   = 5'h00;

    // bit positions inside basic_mode_control
    localparam int BIT_RESET  = 15;
    localparam int BIT_LOOP   = 14;
    localparam int BIT_SPEED  = 13;
    localparam int BIT_AN_EN  = 12;
    localparam int BIT_RSVD   = 11;
    localparam int BIT_DUPLEX = 8;

    // reset values; loop and duplex do not depend on the straps, speed and negotiation do
    localparam logic LOOP_DEF   = 1'h0;
    localparam logic DUPLEX_DEF = 1'h1;
    localparam logic SPEED_DEF  = 1'h1;
    localparam logic AN_DEF     = 1'h1;

    // strap code {autoneg_strap_high, autoneg_strap_low} that enables negotiation
    localparam logic [1:0] STRAP_AN_ON = 2'h3;

    // serial management frame layout
    localparam logic [5:0] PRE_BITS  = 6'h20;
    localparam logic [5:0] HDR_LAST  = 6'h0B;
    localparam logic [5:0] DATA_LAST = 6'h0F;
    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] OP_WRITE  = 2'h1;

    typedef enum logic [2:0] {
        PBM_PRE,
        PBM_START,
        PBM_HDR,
        PBM_TA,
        PBM_DATA
    } pbm_mdio_state_t;

endpackage

// ---- verilog/pbm_mgmt_if.sv ----
`timescale 1ns/10ps
// register access between the serial engine and the register bank
interface pbm_mgmt_if;
    logic        wr_req;   // one-cycle write pulse
    logic [4:0]  regad;    // register address of the current frame
    logic [15:0] wdata;    // write data, valid with wr_req
    logic [15:0] rdata;    // read data for regad

    modport engine (output wr_req, output regad, output wdata, input rdata);
    modport regs   (input wr_req, input regad, input wdata, output rdata);
endinterface

// ---- verilog/pbm_mdio_engine.sv ----
`timescale 1ns/10ps
module pbm_mdio_engine
(
    input  wire logic       clk_in,        // system clock
    input  wire logic       rst_n_in,      // async reset, active low
    input  wire logic       mdc_in,        // management clock pin
    input  wire logic       mdio_in,       // management data pin, input side
    output logic            mdio_out,      // management data pin, output side
    output logic            mdio_oe_n_out, // low while driving the data pin
    input  wire logic [4:0] phy_addr_in,   // this device's management address
    pbm_mgmt_if.engine      mgmt           // register access
);

    logic [2:0]                mdc_s_r;
    logic [2:0]                mdio_s_r;
    logic                      mdio_q_r;
    logic                      mdc_q_r;
    logic                      mdc_rise;
    logic                      bit_in;
    pbm_pkg::pbm_mdio_state_t  state_r;
    logic [5:0]                cnt_r;
    logic [10:0]               hdr_r;
    logic [11:0]               hdr_full;
    logic                      is_read_r;
    logic [15:0]               shift_r;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            mdc_s_r  <= 3'h0;
            mdc_q_r  <= 1'h0;
            mdio_s_r <= 3'h7;
            mdio_q_r <= 1'h1;
        end
        else
        begin
            mdc_s_r  <= {mdc_s_r[1:0], mdc_in};
            if (mdc_s_r[1] == mdc_s_r[2])
                mdc_q_r <= mdc_s_r[2];
            mdio_s_r <= {mdio_s_r[1:0], mdio_in};
            if (mdio_s_r[1] == mdio_s_r[2])
                mdio_q_r <= mdio_s_r[2];
        end
    end

    // data pin is stable long before the clock rises, so the filtered copy is used
    assign mdc_rise = (mdc_s_r[1] == mdc_s_r[2]) & mdc_s_r[2] & ~mdc_q_r;
    assign bit_in   = mdio_q_r;
    assign hdr_full = {hdr_r, bit_in};

    ////////////////////////////////////////////////////////////////////////
    // frame walker: preamble, start, op/address header, turnaround, data
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_r       <= pbm_pkg::PBM_PRE;
            cnt_r         <= 6'h00;
            hdr_r         <= 11'h000;
            is_read_r     <= 1'h0;
            shift_r       <= 16'h0000;
            mdio_out      <= 1'h1;
            mdio_oe_n_out <= 1'h1;
            mgmt.wr_req   <= 1'h0;
            mgmt.regad    <= 5'h00;
            mgmt.wdata    <= 16'h0000;
        end
        else
        begin
            mgmt.wr_req <= 1'h0;
            if (mdc_rise)
            begin
                unique case (state_r)
                    pbm_pkg::PBM_PRE:
                    begin
                        if (bit_in)
                            cnt_r <= (cnt_r == pbm_pkg::PRE_BITS) ? cnt_r : cnt_r + 6'h01;
                        else
                        begin
                            if (cnt_r == pbm_pkg::PRE_BITS)
                                state_r <= pbm_pkg::PBM_START;
                            cnt_r <= 6'h00;
                        end
                    end
                    pbm_pkg::PBM_START:
                    begin
                        state_r <= bit_in ? pbm_pkg::PBM_HDR : pbm_pkg::PBM_PRE;
                        cnt_r   <= 6'h00;
                    end
                    pbm_pkg::PBM_HDR:
                    begin
                        hdr_r <= hdr_full[10:0];
                        cnt_r <= cnt_r + 6'h01;
                        if (cnt_r == pbm_pkg::HDR_LAST)
                        begin
                            cnt_r      <= 6'h00;
                            mgmt.regad <= hdr_full[4:0];
                            is_read_r  <= (hdr_full[11:10] == pbm_pkg::OP_READ);
                            // frames for another address or with a bad opcode are skipped
                            if (hdr_full[9:5] == phy_addr_in &&
                                (hdr_full[11:10] == pbm_pkg::OP_READ || hdr_full[11:10] == pbm_pkg::OP_WRITE))
                                state_r <= pbm_pkg::PBM_TA;
                            else
                                state_r <= pbm_pkg::PBM_PRE;
                        end
                    end
                    pbm_pkg::PBM_TA:
                    begin
                        cnt_r <= cnt_r + 6'h01;
                        if (cnt_r == 6'h00)
                        begin
                            // second turnaround bit is driven low on a read
                            if (is_read_r)
                            begin
                                mdio_out      <= 1'h0;
                                mdio_oe_n_out <= 1'h0;
                            end
                        end
                        else
                        begin
                            cnt_r   <= 6'h00;
                            state_r <= pbm_pkg::PBM_DATA;
                            if (is_read_r)
                            begin
                                mdio_out <= mgmt.rdata[15];
                                shift_r  <= {mgmt.rdata[14:0], 1'h0};
                            end
                        end
                    end
                    pbm_pkg::PBM_DATA:
                    begin
                        cnt_r <= cnt_r + 6'h01;
                        if (is_read_r)
                        begin
                            mdio_out <= shift_r[15];
                            shift_r  <= {shift_r[14:0], 1'h0};
                        end
                        else
                            shift_r <= {shift_r[14:0], bit_in};
                        if (cnt_r == pbm_pkg::DATA_LAST)
                        begin
                            cnt_r         <= 6'h00;
                            state_r       <= pbm_pkg::PBM_PRE;
                            mdio_out      <= 1'h1;
                            mdio_oe_n_out <= 1'h1;
                            if (!is_read_r)
                            begin
                                mgmt.wdata  <= {shift_r[14:0], bit_in};
                                mgmt.wr_req <= 1'h1;
                            end
                        end
                    end
                endcase
            end
        end
    end

endmodule // pbm_mdio_engine

// ---- verilog/pbm_basic_mode_control.sv ----
`timescale 1ns/10ps
module pbm_basic_mode_control
#(
    parameter int DEAD_CYCLES = pbm_pkg::DEAD_CYCLES // loopback dead period in clocks
)
(
    input  wire logic       clk_in,             // 125 MHz system clock
    input  wire logic       rst_n_in,           // async hardware reset, active low
    input  wire logic       mdc_in,             // management clock pin
    input  wire logic       mdio_in,            // management data pin, input side
    output logic            mdio_out,           // management data pin, output side
    output logic            mdio_oe_n_out,      // low while driving the data pin
    input  wire logic [4:0] phy_addr_in,        // device management address
    input  wire logic       autoneg_strap_low_in,  // negotiation strap pin, low bit
    input  wire logic       autoneg_strap_high_in, // negotiation strap pin, high bit
    input  wire logic       an_speed_100_in,    // negotiated speed, one = 100 Mb/s
    input  wire logic       an_full_duplex_in,  // negotiated duplex, one = full
    input  wire logic [1:0] lb_loop_ctrl_in,    // loopback bits 9:8 of the bypass register
    output logic            sw_reset_out,       // level: reset process running
    output logic            mii_loopback_out,   // MII transmit-to-receive loopback on
    output logic [1:0]      lb_loop_ctrl_out,   // bypass-register loopback after override
    output logic            data_hold_out,      // loopback dead period, no data handled
    output logic            autoneg_enable_out, // negotiation actually enabled
    output logic            speed_100_out,      // link speed in use, one = 100 Mb/s
    output logic            full_duplex_out     // duplex in use, one = full
);

    pbm_mgmt_if mgmt ();

    localparam int DW = $clog2(DEAD_CYCLES + 1);

    logic [1:0]                   strap_s1_r;
    logic [1:0]                   strap_s2_r;
    logic [1:0]                   strap_s3_r;
    logic [1:0]                   strap_q_r;
    logic [1:0]                   strap_cap_r;
    logic [1:0]                   strap_now;
    logic [pbm_pkg::RST_CNT_W-1:0] rst_cnt_r;
    logic                         busy;
    logic                         bmc_hit;
    logic                         rst_start;
    logic                         bmc_wr;
    logic                         an_def;
    logic                         speed_def;
    logic                         loop_r;
    logic                         speed_r;
    logic                         an_en_r;
    logic                         duplex_r;
    logic                         an_arm_r;
    logic                         an_eff_r;
    logic [DW-1:0]                dead_cnt_r;

    ////////////////////////////////////////////////////////////////////////
    // serial management engine
    pbm_mdio_engine u_engine
    (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .mdc_in        (mdc_in),
        .mdio_in       (mdio_in),
        .mdio_out      (mdio_out),
        .mdio_oe_n_out (mdio_oe_n_out),
        .phy_addr_in   (phy_addr_in),
        .mgmt          (mgmt.engine)
    );

    ////////////////////////////////////////////////////////////////////////
    // strap synchronisers; a pin change counts once stages two and three agree
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            strap_s1_r <= 2'h0;
            strap_s2_r <= 2'h0;
            strap_s3_r <= 2'h0;
            strap_q_r  <= 2'h0;
        end
        else
        begin
            strap_s1_r <= {autoneg_strap_high_in, autoneg_strap_low_in};
            strap_s2_r <= strap_s1_r;
            strap_s3_r <= strap_s2_r;
            strap_q_r  <= (strap_q_r & (strap_s2_r ^ strap_s3_r)) | (strap_s3_r & ~(strap_s2_r ^ strap_s3_r));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset process: hardware reset loads the counter, so both resets share one path
    assign busy      = (rst_cnt_r != '0);
    assign bmc_hit   = mgmt.wr_req && (mgmt.regad == pbm_pkg::REG_BMC);
    assign rst_start = bmc_hit && mgmt.wdata[pbm_pkg::BIT_RESET] && !busy;
    // writes that land while reset runs are dropped, including a zero to bit 15
    assign bmc_wr    = bmc_hit && !mgmt.wdata[pbm_pkg::BIT_RESET] && !busy;

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            rst_cnt_r <= pbm_pkg::RST_LOAD;
        else if (rst_start)
            rst_cnt_r <= pbm_pkg::RST_LOAD;
        else if (busy)
            rst_cnt_r <= rst_cnt_r - pbm_pkg::RST_LAST;
    end

    // straps are taken in the last reset cycle, after the synchroniser has settled
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            strap_cap_r <= pbm_pkg::STRAP_AN_ON;
        else if (rst_cnt_r == pbm_pkg::RST_LAST)
            strap_cap_r <= strap_q_r;
    end

    // strap-derived reset values; forced speed follows the low strap
    assign strap_now = (rst_cnt_r == pbm_pkg::RST_LAST) ? strap_q_r : strap_cap_r;
    assign an_def    = (strap_now == pbm_pkg::STRAP_AN_ON);
    assign speed_def = an_def ? pbm_pkg::SPEED_DEF : strap_now[0];

    ////////////////////////////////////////////////////////////////////////
    // control bits; defaults reload every reset cycle so the last capture wins
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            loop_r   <= pbm_pkg::LOOP_DEF;
            speed_r  <= pbm_pkg::SPEED_DEF;
            an_en_r  <= pbm_pkg::AN_DEF;
            duplex_r <= pbm_pkg::DUPLEX_DEF;
        end
        else if (busy || rst_start)
        begin
            loop_r   <= pbm_pkg::LOOP_DEF;
            speed_r  <= speed_def;
            an_en_r  <= an_def;
            duplex_r <= pbm_pkg::DUPLEX_DEF;
        end
        else if (bmc_wr)
        begin
            loop_r   <= mgmt.wdata[pbm_pkg::BIT_LOOP];
            speed_r  <= mgmt.wdata[pbm_pkg::BIT_SPEED];
            an_en_r  <= mgmt.wdata[pbm_pkg::BIT_AN_EN];
            duplex_r <= mgmt.wdata[pbm_pkg::BIT_DUPLEX];
        end
    end

    // negotiation only turns on after a zero has been written when reset left it off
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            an_arm_r <= pbm_pkg::AN_DEF;
            an_eff_r <= pbm_pkg::AN_DEF;
        end
        else if (busy || rst_start)
        begin
            an_arm_r <= an_def;
            an_eff_r <= an_def;
        end
        else if (bmc_wr)
        begin
            if (!mgmt.wdata[pbm_pkg::BIT_AN_EN])
            begin
                an_arm_r <= 1'h1;
                an_eff_r <= 1'h0;
            end
            else if (an_arm_r)
                an_eff_r <= 1'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // loopback dead period, only when turned on while running at 100 Mb/s
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            dead_cnt_r <= '0;
        else if (busy || rst_start)
            dead_cnt_r <= '0;
        else if (bmc_wr && mgmt.wdata[pbm_pkg::BIT_LOOP] && !loop_r && speed_100_out)
            dead_cnt_r <= DW'(DEAD_CYCLES);
        else if (dead_cnt_r != '0)
            dead_cnt_r <= dead_cnt_r - DW'(1);
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs toward the datapath
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sw_reset_out       <= 1'h1;
            mii_loopback_out   <= pbm_pkg::LOOP_DEF;
            lb_loop_ctrl_out   <= 2'h0;
            data_hold_out      <= 1'h0;
            autoneg_enable_out <= pbm_pkg::AN_DEF;
            speed_100_out      <= pbm_pkg::SPEED_DEF;
            full_duplex_out    <= pbm_pkg::DUPLEX_DEF;
        end
        else
        begin
            sw_reset_out       <= busy;
            mii_loopback_out   <= loop_r;
            // the control-register loopback masks the bypass-register loopback modes
            lb_loop_ctrl_out   <= loop_r ? 2'h0 : lb_loop_ctrl_in;
            data_hold_out      <= (dead_cnt_r != '0);
            autoneg_enable_out <= an_eff_r;
            speed_100_out      <= an_eff_r ? an_speed_100_in : speed_r;
            full_duplex_out    <= an_eff_r ? an_full_duplex_in : duplex_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data; bit 11 and unimplemented bits read zero, other addresses read zero
    always_comb
    begin
        mgmt.rdata = 16'h0000;
        if (mgmt.regad == pbm_pkg::REG_BMC)
        begin
            mgmt.rdata[pbm_pkg::BIT_RESET]  = busy;
            mgmt.rdata[pbm_pkg::BIT_LOOP]   = loop_r;
            mgmt.rdata[pbm_pkg::BIT_SPEED]  = speed_r;
            mgmt.rdata[pbm_pkg::BIT_AN_EN]  = an_en_r;
            mgmt.rdata[pbm_pkg::BIT_RSVD]   = 1'h0;
            mgmt.rdata[pbm_pkg::BIT_DUPLEX] = duplex_r;
        end
    end

endmodule // pbm_basic_mode_control

// ---- verification/pbm_monitor.sv ----
`timescale 1ns/10ps
// watches the top ports only; attached by bind from the bench
module pbm_monitor
#(
    parameter int DEAD_CYCLES = 20 // dead period length in clocks
)
(
    input wire logic       clk_in,                // system clock
    input wire logic       rst_n_in,              // async reset, active low
    input wire logic       mdc_in,                // management clock pin
    input wire logic       mdio_in,               // management data pin
    input wire logic       mdio_out,              // data pin output side
    input wire logic       mdio_oe_n_out,         // data pin enable, low drives
    input wire logic [4:0] phy_addr_in,           // device address
    input wire logic       autoneg_strap_low_in,  // strap pin, low bit
    input wire logic       autoneg_strap_high_in, // strap pin, high bit
    input wire logic       an_speed_100_in,       // negotiated speed
    input wire logic       an_full_duplex_in,     // negotiated duplex
    input wire logic [1:0] lb_loop_ctrl_in,       // bypass-register loopback bits
    input wire logic       sw_reset_out,          // reset process running
    input wire logic       mii_loopback_out,      // loopback on
    input wire logic [1:0] lb_loop_ctrl_out,      // bypass loopback after override
    input wire logic       data_hold_out,         // dead period
    input wire logic       autoneg_enable_out,    // negotiation in effect
    input wire logic       speed_100_out,         // speed in use
    input wire logic       full_duplex_out        // duplex in use
);
    int dead_cnt;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////////////////////////////////////////
    // length of the running dead period, so its end can be timed exactly
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            dead_cnt <= 0;
        else
            dead_cnt <= data_hold_out ? dead_cnt + 1 : 0;
    end
    loop_override_a: assert property (
        mii_loopback_out && $past(mii_loopback_out) |-> lb_loop_ctrl_out == 2'h0)
        else $error("bypass loopback not overridden");
    loop_pass_a: assert property (
        !mii_loopback_out && !$past(mii_loopback_out) && !sw_reset_out |-> lb_loop_ctrl_out == $past(lb_loop_ctrl_in))
        else $error("bypass loopback not passed through");
    an_speed_a: assert property (
        (autoneg_enable_out && $stable(an_speed_100_in))[*3] |-> speed_100_out == an_speed_100_in)
        else $error("speed not taken from negotiation");
    an_duplex_a: assert property (
        (autoneg_enable_out && $stable(an_full_duplex_in))[*3] |-> full_duplex_out == an_full_duplex_in)
        else $error("duplex not taken from negotiation");
    dead_len_a: assert property (
        $fell(data_hold_out) && !sw_reset_out |-> dead_cnt == DEAD_CYCLES)
        else $error("dead period length wrong");
    dead_speed_a: assert property (
        $rose(data_hold_out) |-> $past(speed_100_out))
        else $error("dead period outside 100 Mb/s");
    reset_len_a: assert property (
        $rose(sw_reset_out) |-> sw_reset_out[*8] ##[0:2] !sw_reset_out)
        else $error("reset process length wrong");
    reset_defaults_a: assert property (
        $fell(sw_reset_out) ##1 1'b1 |-> !mii_loopback_out
            && autoneg_enable_out == (autoneg_strap_low_in && autoneg_strap_high_in)
            && (autoneg_enable_out || speed_100_out == autoneg_strap_low_in))
        else $error("defaults or straps wrong after reset");
endmodule // pbm_monitor

// ---- verification/pbm_sta_model.sv ----
`timescale 1ns/10ps
// station management controller: makes frames on the serial pins
module pbm_sta_model
(
    input  wire logic clk_in,       // system clock, paces the pins
    input  wire logic mdio_in,      // resolved data line level
    output logic      mdc_out,      // management clock, still between frames
    output logic      mdio_out,     // data driven by the controller
    output logic      mdio_oe_n_out // low while the controller drives
);
    localparam int HALF = 6; // clocks per mdc half, above the minimum of four
    initial
    begin
        mdc_out = 1'b0;
        mdio_out = 1'b1;
        mdio_oe_n_out = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic half_wait();
        repeat (HALF) @(posedge clk_in);
        #1;
    endtask
    // one bit: data set while mdc is low, sampled just before mdc rises
    task automatic bit_slot(input logic drive, input logic val, output logic smp);
        mdio_oe_n_out = !drive;
        mdio_out = val;
        half_wait();
        smp = mdio_in;
        mdc_out = 1'b1;
        half_wait();
        mdc_out = 1'b0;
    endtask
    // whole frame; fresh preamble every time, bit 11 always written zero
    task automatic frame(input logic [4:0] phy, input logic rd, input logic [4:0] regad,
                         input logic [15:0] wd, output logic [15:0] q);
        logic        s;
        logic [13:0] hdr;
        hdr = {2'h1, rd ? pbm_pkg::OP_READ : pbm_pkg::OP_WRITE, phy, regad};
        repeat (32) bit_slot(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_slot(1'b1, hdr[i], s);
        bit_slot(!rd, 1'b1, s);
        bit_slot(!rd, 1'b0, s);
        for (int i = 15; i >= 0; i--)
        begin
            bit_slot(!rd, wd[i] & (i != 11), s);
            q[i] = s;
        end
        mdio_oe_n_out = 1'b1;
        half_wait();
    endtask
endmodule // pbm_sta_model

// ---- verification/test_phy_basic_mode_control_upper.sv ----
`timescale 1ns/10ps
module test_phy_basic_mode_control_upper;
    localparam int         DEAD = 20;    // shortened dead period
    localparam logic [4:0] PHY  = 5'h05; // address given to the device
    logic       clk_in, rst_n_in = 1'b0, mdc, sta_out, sta_oe_n, dut_out, dut_oe_n;
    logic       strap_lo = 1'b1, strap_hi = 1'b1, an_spd = 1'b1, an_dup = 1'b1;
    logic       sw_reset, loop, hold, an_en, spd, dup;
    logic [1:0] lb_in = 2'h3, lb_out;
    wire        mdio_line = !sta_oe_n ? sta_out : (!dut_oe_n ? dut_out : 1'b1); // pull-up when idle
    int         num_errors = 0;
    int         samples_checked = 0;
    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    pbm_sta_model sta_u (.clk_in(clk_in), .mdio_in(mdio_line), .mdc_out(mdc), .mdio_out(sta_out),
        .mdio_oe_n_out(sta_oe_n));
    pbm_basic_mode_control #(.DEAD_CYCLES(DEAD)) dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .mdc_in(mdc), .mdio_in(mdio_line), .mdio_out(dut_out), .mdio_oe_n_out(dut_oe_n),
        .phy_addr_in(PHY), .autoneg_strap_low_in(strap_lo), .autoneg_strap_high_in(strap_hi),
        .an_speed_100_in(an_spd), .an_full_duplex_in(an_dup), .lb_loop_ctrl_in(lb_in),
        .sw_reset_out(sw_reset), .mii_loopback_out(loop), .lb_loop_ctrl_out(lb_out),
        .data_hold_out(hold), .autoneg_enable_out(an_en), .speed_100_out(spd), .full_duplex_out(dup));
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // status bits: loop, hold, bypass loopback, negotiation, speed, duplex
    task automatic chk_st(input logic [6:0] e);
        chk({9'h000, loop, hold, lb_out, an_en, spd, dup}, {9'h000, e});
    endtask
    // write, then let the register update reach the outputs
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        sta_u.frame(PHY, 1'b0, a, d, q);
        repeat (6) @(posedge clk_in);
        #1;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] q;
        sta_u.frame(PHY, 1'b1, a, 16'h0000, q);
        chk(q, exp);
    endtask
    // bounded wait for the reset process to end
    task automatic wait_idle();
        int n;
        for (n = 0; n < 40 && sw_reset !== 1'b0; n++) @(posedge clk_in);
        #1;
        if (n == 40)
        begin
            num_errors++;
            final_report();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [15:0] q;
        repeat (16) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        wait_idle();
        rd(5'h00, 16'h3100);
        chk_st(7'h1F);
        wr(5'h00, 16'h2000);
        chk_st(7'h1A);
        wr(5'h00, 16'h0100);
        chk_st(7'h19);
        wr(5'h00, 16'h1000);
        an_spd = 1'b0;
        an_dup = 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        chk_st(7'h1C);
        rd(5'h00, 16'h1000);
        an_spd = 1'b1;
        an_dup = 1'b1;
        wr(5'h00, 16'h2000);
        wr(5'h00, 16'h6000);
        chk_st(7'h62);
        repeat (DEAD + 4) @(posedge clk_in);
        #1;
        chk_st(7'h42);
        rd(5'h00, 16'h6000);
        strap_hi = 1'b0;
        while ($time < 500000) @(posedge clk_in);
        #1;
        wr(5'h00, 16'h8000);
        wait_idle();
        chk_st(7'h1B);
        rd(5'h00, 16'h2100);
        wr(5'h00, 16'h1000);
        chk_st(7'h18);
        wr(5'h00, 16'h0000);
        wr(5'h00, 16'h1000);
        chk_st(7'h1F);
        wr(5'h01, 16'hFFFF);
        rd(5'h01, 16'h0000);
        chk({15'h0000, sw_reset}, 16'h0000);
        sta_u.frame(PHY + 5'h01, 1'b0, 5'h00, 16'h4000, q);
        chk_st(7'h1F);
        final_report();
    end
endmodule // test_phy_basic_mode_control_upper

bind pbm_basic_mode_control pbm_monitor #(.DEAD_CYCLES(DEAD_CYCLES)) mon_u (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .mdc_in(mdc_in), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe_n_out(mdio_oe_n_out), .phy_addr_in(phy_addr_in), .autoneg_strap_low_in(autoneg_strap_low_in),
    .autoneg_strap_high_in(autoneg_strap_high_in), .an_speed_100_in(an_speed_100_in),
    .an_full_duplex_in(an_full_duplex_in), .lb_loop_ctrl_in(lb_loop_ctrl_in), .sw_reset_out(sw_reset_out),
    .mii_loopback_out(mii_loopback_out), .lb_loop_ctrl_out(lb_loop_ctrl_out), .data_hold_out(data_hold_out),
    .autoneg_enable_out(autoneg_enable_out), .speed_100_out(speed_100_out), .full_duplex_out(full_duplex_out));
